// ===== core/ssp_pkg.sv
// Constants, field layouts and carrier types for the serial programming block.
// How it works
// - Three wires: shift clock, strobe, data.
// - Words are 24 bits with address bits.
// - Strobe high freezes the shift register.
// - Strobe decodes address, loads working or staging.
// - DAC bits staged until main word latches.
// - Power state is pin XOR software bit.
// - Dividers resynchronised when leaving power-down.
// - Lock output is main AND auxiliary lock.
// - Lock means phase error under one period.
// - One synthesizer off: other alone sets lock.
// - Both synthesizers off: lock output is 0.
// - Scale bit picks high or low currents.
// - Disable bit turns off integral pump only.
// - Aux pump from aux detector, main from main.
// - Main word: address, modulus, increment, ratio, spares.
// - Modulus select: 1 is mod 5, 0 mod 8.
package ssp_pkg;

  localparam int WORD_W = 24;

  // Word bit 23 is the last bit shifted in.
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 22;

  localparam logic [1:0] ADDR_MAIN = 2'h0;
  localparam logic [1:0] ADDR_REF = 2'h1;
  localparam logic [1:0] ADDR_AUX = 2'h2;
  localparam logic [1:0] ADDR_TEST = 2'h3;

  // Main-divider word fields.
  localparam int A_FM = 21;
  localparam int A_NF_HI = 20;
  localparam int A_NF_LO = 18;
  localparam int A_N_HI = 17;
  localparam int A_N_LO = 2;
  localparam int A_SPARE_A = 1;
  localparam int A_SPARE_B = 0;

  // Reference/power/DAC word fields.
  localparam int B_R_HI = 21;
  localparam int B_R_LO = 12;
  localparam int B_L_HI = 11;
  localparam int B_L_LO = 10;
  localparam int B_PD_MAIN = 9;
  localparam int B_PD_AUX = 8;
  localparam int B_FC_HI = 7;
  localparam int B_FC_LO = 0;

  // Auxiliary word fields.
  localparam int C_A_HI = 21;
  localparam int C_A_LO = 8;
  localparam int C_CP1 = 7;
  localparam int C_CP0 = 6;
  localparam int C_SM_HI = 5;
  localparam int C_SM_LO = 3;
  localparam int C_SA_HI = 2;
  localparam int C_SA_LO = 0;

  // Values after reset.
  localparam logic RST_FM = 1'h0;
  localparam logic [2:0] RST_NF = 3'h2;
  localparam logic [15:0] RST_N = 16'h2230;
  localparam logic [9:0] RST_R = 10'h051;
  localparam logic [1:0] RST_LOCK_MODE = 2'h0;
  localparam logic RST_PD_MAIN = 1'h1;
  localparam logic RST_PD_AUX = 1'h1;
  localparam logic [7:0] RST_FC = 8'h50;
  localparam logic [13:0] RST_A = 14'h01CA;
  localparam logic RST_CP1 = 1'h1;
  localparam logic RST_CP0 = 1'h1;
  localparam logic [2:0] RST_SM = 3'h0;
  localparam logic [2:0] RST_SA = 3'h0;

  // Accumulator moduli.
  localparam logic [3:0] MOD_FIVE = 4'h5;
  localparam logic [3:0] MOD_EIGHT = 4'h8;

  // Pump current multiples of the bias current, in half units.
  localparam logic [7:0] GAIN_AUX_HI = 8'h03;
  localparam logic [7:0] GAIN_AUX_LO = 8'h01;
  localparam logic [7:0] GAIN_PROP_HI = 8'h06;
  localparam logic [7:0] GAIN_PROP_LO = 8'h02;
  localparam logic [7:0] GAIN_SU_HI = 8'h1E;
  localparam logic [7:0] GAIN_SU_LO = 8'h0A;
  localparam logic [7:0] GAIN_INT_HI = 8'h48;
  localparam logic [7:0] GAIN_INT_LO = 8'h18;
  localparam logic [7:0] GAIN_OFF = 8'h00;

  typedef struct packed {
    logic up;
    logic dn;
  } ssp_pump_s;

  typedef struct packed {
    logic [7:0] aux;
    logic [7:0] prop;
    logic [7:0] speedup;
    logic [7:0] integral;
  } ssp_gain_s;

endpackage : ssp_pkg

// ===== core/ssp_power_lock.sv
// Power state, divider resynchronisation and combined lock detection.
`timescale 1ns/1ps
module ssp_power_lock
  import ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hw_power_pin,
  input wire logic sw_power_bit_main,
  input wire logic sw_power_bit_aux,
  input wire logic main_pd_locked,
  input wire logic aux_pd_locked,
  output logic main_on,
  output logic aux_on,
  output logic divider_resync,
  output logic lock_out
);

  logic next_main_on;
  logic next_aux_on;
  logic next_lock;

  assign next_main_on = hw_power_pin ^ sw_power_bit_main;
  assign next_aux_on = hw_power_pin ^ sw_power_bit_aux;

  assign next_lock = (next_main_on | next_aux_on) & (~next_main_on | main_pd_locked) &
                     (~next_aux_on | aux_pd_locked);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_on <= 1'h0;
      aux_on <= 1'h0;
    end else begin
      main_on <= next_main_on;
      aux_on <= next_aux_on;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      divider_resync <= 1'h0;
    end else begin
      divider_resync <= (next_main_on & ~main_on) | (next_aux_on & ~aux_on);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_out <= 1'h0;
    end else begin
      lock_out <= next_lock;
    end
  end

endmodule : ssp_power_lock

// ===== core/ssp_top.sv
// Serial programming receiver, word registers and pump control for the synthesizer.
`timescale 1ns/1ps
module ssp_top
  import ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_strobe,
  input wire logic ser_data,
  input wire logic hw_power_pin,
  input wire logic main_pd_locked,
  input wire logic aux_pd_locked,
  input wire ssp_pump_s main_pd,
  input wire ssp_pump_s aux_pd,
  output logic lock_out,
  output logic main_on,
  output logic aux_on,
  output logic divider_resync,
  output logic modulus_select,
  output logic [3:0] accum_modulus,
  output logic [2:0] frac_increment,
  output logic [15:0] main_ratio,
  output logic spare_bit_a,
  output logic spare_bit_b,
  output logic main_load,
  output logic [7:0] comp_dac,
  output logic [9:0] ref_ratio,
  output logic [1:0] lock_mode,
  output logic [13:0] aux_ratio,
  output logic integral_disable_code_bit,
  output logic current_scale_code_bit,
  output logic [2:0] main_cmp_sel,
  output logic [2:0] aux_cmp_sel,
  output ssp_gain_s pump_gain,
  output ssp_pump_s aux_pump_out,
  output ssp_pump_s main_prop_pump_out,
  output ssp_pump_s main_integral_pump_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial input.

  logic [WORD_W-1:0] shift_reg;
  logic ser_clk_q;
  logic strobe_q;
  logic ser_rise;
  logic strobe_rise;
  logic [1:0] word_addr;
  logic sw_power_bit_main;
  logic sw_power_bit_aux;
  logic [7:0] comp_dac_stage;

  assign ser_rise = ser_clk & ~ser_clk_q;
  assign strobe_rise = ser_strobe & ~strobe_q;
  assign word_addr = shift_reg[ADDR_HI:ADDR_LO];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ser_clk_q <= 1'h0;
      strobe_q <= 1'h0;
    end else begin
      ser_clk_q <= ser_clk;
      strobe_q <= ser_strobe;
    end
  end

  // The first bit in ends at bit 0, so the last two in sit on top as the address.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (ser_rise && !ser_strobe) begin
      shift_reg <= {ser_data, shift_reg[WORD_W-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word decode and registers.

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      modulus_select <= RST_FM;
      frac_increment <= RST_NF;
      main_ratio <= RST_N;
      spare_bit_a <= 1'h0;
      spare_bit_b <= 1'h0;
      comp_dac <= RST_FC;
    end else if (strobe_rise && word_addr == ADDR_MAIN) begin
      modulus_select <= shift_reg[A_FM];
      frac_increment <= shift_reg[A_NF_HI:A_NF_LO];
      main_ratio <= shift_reg[A_N_HI:A_N_LO];
      spare_bit_a <= shift_reg[A_SPARE_A];
      spare_bit_b <= shift_reg[A_SPARE_B];
      comp_dac <= comp_dac_stage;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_load <= 1'h0;
    end else begin
      main_load <= strobe_rise && word_addr == ADDR_MAIN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ref_ratio <= RST_R;
      lock_mode <= RST_LOCK_MODE;
    end else if (strobe_rise && word_addr == ADDR_REF) begin
      ref_ratio <= shift_reg[B_R_HI:B_R_LO];
      lock_mode <= shift_reg[B_L_HI:B_L_LO];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_power_bit_main <= RST_PD_MAIN;
      sw_power_bit_aux <= RST_PD_AUX;
    end else if (strobe_rise && word_addr == ADDR_REF) begin
      sw_power_bit_main <= shift_reg[B_PD_MAIN];
      sw_power_bit_aux <= shift_reg[B_PD_AUX];
    end
  end

  // DAC bits staged only
  // Only a main word latch reads the stage, so a reference word alone never moves the DAC.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      comp_dac_stage <= RST_FC;
    end else if (strobe_rise && word_addr == ADDR_REF) begin
      comp_dac_stage <= shift_reg[B_FC_HI:B_FC_LO];
    end
  end

  // auxiliary word load
  // The test word address loads nothing, so a stray test write is harmless.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_ratio <= RST_A;
      integral_disable_code_bit <= RST_CP1;
      current_scale_code_bit <= RST_CP0;
      main_cmp_sel <= RST_SM;
      aux_cmp_sel <= RST_SA;
    end else if (strobe_rise && word_addr == ADDR_AUX) begin
      aux_ratio <= shift_reg[C_A_HI:C_A_LO];
      integral_disable_code_bit <= shift_reg[C_CP1];
      current_scale_code_bit <= shift_reg[C_CP0];
      main_cmp_sel <= shift_reg[C_SM_HI:C_SM_LO];
      aux_cmp_sel <= shift_reg[C_SA_HI:C_SA_LO];
    end
  end

  assign accum_modulus = modulus_select ? MOD_FIVE : MOD_EIGHT;

  ////////////////////////////////////////////////////////////////////////////
  // Power and lock.

  ssp_power_lock u_power_lock (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hw_power_pin(hw_power_pin),
    .sw_power_bit_main(sw_power_bit_main),
    .sw_power_bit_aux(sw_power_bit_aux),
    .main_pd_locked(main_pd_locked),
    .aux_pd_locked(aux_pd_locked),
    .main_on(main_on),
    .aux_on(aux_on),
    .divider_resync(divider_resync),
    .lock_out(lock_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Charge pump control.

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pump_gain <= '0;
    end else begin
      pump_gain.aux <= current_scale_code_bit ? GAIN_AUX_LO : GAIN_AUX_HI;
      pump_gain.prop <= current_scale_code_bit ? GAIN_PROP_LO : GAIN_PROP_HI;
      pump_gain.speedup <= current_scale_code_bit ? GAIN_SU_LO : GAIN_SU_HI;
      pump_gain.integral <= integral_disable_code_bit ? GAIN_OFF :
                            (current_scale_code_bit ? GAIN_INT_LO : GAIN_INT_HI);
    end
  end

  // Pumps of a powered-down synthesizer stay idle so they cannot disturb the loop.
  // aux detector drives
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_pump_out <= '0;
    end else begin
      aux_pump_out <= aux_on ? aux_pd : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_prop_pump_out <= '0;
    end else begin
      main_prop_pump_out <= main_on ? main_pd : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      main_integral_pump_out <= '0;
    end else begin
      main_integral_pump_out <= (main_on && !integral_disable_code_bit) ? main_pd : '0;
    end
  end

endmodule : ssp_top

// ===== test/ssp_host_model.sv
// Host model that drives the three-wire programming bus.
`timescale 1ns/1ps
module ssp_host_model (
  input wire logic ref_clk,
  output logic ser_clk,
  output logic ser_strobe,
  output logic ser_data
);
  initial begin
    ser_clk = 1'h0;
    ser_strobe = 1'h0;
    ser_data = 1'h0;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask : tick

  task automatic send(input logic [23:0] w, input int n, input int slow);
    for (int i = 0; i < n; i++) begin
      ser_data = w[i];
      ser_clk = 1'h0;
      tick(1 + slow);
      ser_clk = 1'h1;
      tick(1 + slow);
    end
    ser_clk = 1'h0;
    ser_data = ~ser_data;
    tick(1);
    // clock noise while latched
    // The real host may keep clocking here, so the model does so to be no kinder.
    ser_strobe = 1'h1;
    repeat (4) begin
      tick(1);
      ser_clk = ~ser_clk;
      ser_data = ~ser_data;
    end
    tick(1);
    ser_strobe = 1'h0;
    tick(2);
  endtask : send
endmodule : ssp_host_model

// ===== test/ssp_top_monitor.sv
// Concurrent checks on the ports of the synthesizer programming block.
`timescale 1ns/1ps
module ssp_top_monitor
  import ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic main_pd_locked,
  input wire logic aux_pd_locked,
  input wire ssp_pump_s main_pd,
  input wire ssp_pump_s aux_pd,
  input wire logic lock_out,
  input wire logic main_on,
  input wire logic aux_on,
  input wire logic divider_resync,
  input wire logic modulus_select,
  input wire logic [3:0] accum_modulus,
  input wire logic main_load,
  input wire logic [7:0] comp_dac,
  input wire logic integral_disable_code_bit,
  input wire logic current_scale_code_bit,
  input wire ssp_gain_s pump_gain,
  input wire ssp_pump_s aux_pump_out,
  input wire ssp_pump_s main_prop_pump_out,
  input wire ssp_pump_s main_integral_pump_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_lock_both;
    main_on && aux_on |-> lock_out == ($past(main_pd_locked) && $past(aux_pd_locked));
  endproperty
  a_lock_both: assert property (p_lock_both) else $error("lock both");
  property p_lock_one;
    main_on != aux_on |-> lock_out == (main_on ? $past(main_pd_locked) : $past(aux_pd_locked));
  endproperty
  a_lock_one: assert property (p_lock_one) else $error("lock one");
  property p_lock_off;
    !main_on && !aux_on |-> !lock_out;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock off");
  property p_resync;
    divider_resync == ($rose(main_on) || $rose(aux_on));
  endproperty
  a_resync: assert property (p_resync) else $error("resync");
  property p_modulus;
    accum_modulus == (modulus_select ? MOD_FIVE : MOD_EIGHT);
  endproperty
  a_modulus: assert property (p_modulus) else $error("modulus");
  property p_int_off;
    integral_disable_code_bit && $past(integral_disable_code_bit) |->
      pump_gain.integral == GAIN_OFF && main_integral_pump_out == 2'h0;
  endproperty
  a_int_off: assert property (p_int_off) else $error("integral");
  property p_scale;
    $past(rst_n) |-> {pump_gain.aux, pump_gain.prop, pump_gain.speedup} ==
      ($past(current_scale_code_bit) ? {GAIN_AUX_LO, GAIN_PROP_LO, GAIN_SU_LO} :
      {GAIN_AUX_HI, GAIN_PROP_HI, GAIN_SU_HI});
  endproperty
  a_scale: assert property (p_scale) else $error("scale");
  property p_int_on;
    $past(rst_n) && !$past(integral_disable_code_bit) |->
      pump_gain.integral == ($past(current_scale_code_bit) ? GAIN_INT_LO : GAIN_INT_HI);
  endproperty
  a_int_on: assert property (p_int_on) else $error("integral gain");
  property p_int_pump;
    $past(rst_n) && $past(main_on) && !$past(integral_disable_code_bit) |->
      main_integral_pump_out == $past(main_pd);
  endproperty
  a_int_pump: assert property (p_int_pump) else $error("integral pump");
  property p_pump;
    $past(aux_on) && aux_on && $past(main_on) && main_on |->
      {aux_pump_out, main_prop_pump_out} == {$past(aux_pd), $past(main_pd)};
  endproperty
  a_pump: assert property (p_pump) else $error("pump");
  property p_dac;
    $changed(comp_dac) |-> main_load;
  endproperty
  a_dac: assert property (p_dac) else $error("dac");
endmodule : ssp_top_monitor

bind ssp_top ssp_top_monitor ssp_top_monitor_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .main_pd_locked(main_pd_locked),
  .aux_pd_locked(aux_pd_locked), .main_pd(main_pd), .aux_pd(aux_pd), .lock_out(lock_out),
  .main_on(main_on), .aux_on(aux_on), .divider_resync(divider_resync),
  .modulus_select(modulus_select), .accum_modulus(accum_modulus), .main_load(main_load),
  .comp_dac(comp_dac), .integral_disable_code_bit(integral_disable_code_bit),
  .current_scale_code_bit(current_scale_code_bit), .pump_gain(pump_gain),
  .aux_pump_out(aux_pump_out), .main_prop_pump_out(main_prop_pump_out),
  .main_integral_pump_out(main_integral_pump_out));

// ===== test/testbench.sv
// Self-checking bench for the synthesizer serial programming block.
`timescale 1ns/1ps
module testbench
  import ssp_pkg::*;
;
  logic ref_clk, rst_n, ser_clk, ser_strobe, ser_data, hw_power_pin;
  logic main_pd_locked, aux_pd_locked, modulus_select, spare_bit_a, spare_bit_b;
  logic integral_disable_code_bit, current_scale_code_bit, main_on, aux_on;
  logic [2:0] frac_increment, main_cmp_sel, aux_cmp_sel;
  logic [15:0] main_ratio;
  logic [7:0] comp_dac, efc;
  logic [9:0] ref_ratio;
  logic [1:0] lock_mode;
  logic [13:0] aux_ratio;
  logic [23:0] em, eb, ec, w, r;
  ssp_pump_s main_pd, aux_pd;
  int seed, n_fail, n_tests;

  ssp_top ssp_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .ser_clk(ser_clk),
    .ser_strobe(ser_strobe), .ser_data(ser_data), .hw_power_pin(hw_power_pin),
    .main_pd_locked(main_pd_locked), .aux_pd_locked(aux_pd_locked), .main_pd(main_pd),
    .aux_pd(aux_pd), .lock_out(), .main_on(main_on), .aux_on(aux_on), .divider_resync(),
    .modulus_select(modulus_select), .accum_modulus(), .frac_increment(frac_increment),
    .main_ratio(main_ratio), .spare_bit_a(spare_bit_a), .spare_bit_b(spare_bit_b),
    .main_load(), .comp_dac(comp_dac), .ref_ratio(ref_ratio), .lock_mode(lock_mode),
    .aux_ratio(aux_ratio), .integral_disable_code_bit(integral_disable_code_bit),
    .current_scale_code_bit(current_scale_code_bit), .main_cmp_sel(main_cmp_sel),
    .aux_cmp_sel(aux_cmp_sel), .pump_gain(), .aux_pump_out(), .main_prop_pump_out(),
    .main_integral_pump_out());
  ssp_host_model ssp_host_model_i (.ref_clk(ref_clk), .ser_clk(ser_clk),
    .ser_strobe(ser_strobe), .ser_data(ser_data));

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    #2;
    {main_pd_locked, aux_pd_locked, main_pd, aux_pd} = 6'($random(seed));
  end

  function automatic logic on_exp(input logic pin, input logic pd);
    return pin ^ pd;
  endfunction : on_exp

  task automatic final_report();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_all();
    chk({2'h0, modulus_select, frac_increment, main_ratio, spare_bit_a, spare_bit_b},
      {2'h0, em[21:0]});
    chk({12'h0, ref_ratio, lock_mode}, {12'h0, eb[21:10]});
    chk({2'h0, aux_ratio, integral_disable_code_bit, current_scale_code_bit,
      main_cmp_sel, aux_cmp_sel}, {2'h0, ec[21:0]});
    chk({16'h0, comp_dac}, {16'h0, efc});
    chk({22'h0, main_on, aux_on},
      {22'h0, on_exp(hw_power_pin, eb[9]), on_exp(hw_power_pin, eb[8])});
  endtask : chk_all

  task automatic put(input logic [1:0] a, input logic [23:0] d);
    w = {a, d[21:0]};
    case (a)
      ADDR_MAIN: em = w;
      ADDR_REF: eb = w;
      ADDR_AUX: ec = w;
      default: ;
    endcase
    if (a == ADDR_MAIN) efc = eb[7:0];
    ssp_host_model_i.send(w, 24, int'($unsigned($random(seed)) % 3));
    chk_all();
  endtask : put

  initial begin
    seed = 32'h4523;
    n_fail = 0;
    n_tests = 0;
    rst_n = 1'h0;
    hw_power_pin = 1'h0;
    em = {ADDR_MAIN, RST_FM, RST_NF, RST_N, 2'h0};
    eb = {ADDR_REF, RST_R, RST_LOCK_MODE, RST_PD_MAIN, RST_PD_AUX, RST_FC};
    ec = {ADDR_AUX, RST_A, RST_CP1, RST_CP0, RST_SM, RST_SA};
    efc = RST_FC;
    repeat (2) @(posedge ref_clk);
    #2;
    rst_n = 1'h1;
    @(posedge ref_clk);
    #2;
    chk_all();
    for (int i = 0; i < 14; i++) begin
      hw_power_pin = 1'($random(seed));
      put(ADDR_AUX, 24'($random(seed)));
      put(ADDR_REF, 24'($random(seed)));
      r = 24'($random(seed));
      // Ratio stays in the legal range; the last two passes hit its ends.
      r[17:2] = 16'h0200 + 16'($unsigned($random(seed)) % 32'hFE00);
      if (i >= 12) r[17:2] = (i == 12) ? 16'h0200 : 16'hFFFF;
      put(ADDR_MAIN, r);
    end
    ssp_host_model_i.send(24'h000000, 0, 0);
    chk_all();
    put(ADDR_TEST, 24'($random(seed)));
    final_report();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
endmodule : testbench
